//--- include/clkgen_pkg.sv
/*
 * constants for the clock generator reprogramming block: apb offsets,
 * field positions, reset values (also the nv page-zero image), codes
 * and timing counts.
 * assumes a 200 MHz system clock and a 32-bit apb master.
 */
package clkgen_pkg;
    // clock and restart timing
    localparam int CLK_MHZ         = 200;           // system clock rate
    localparam int RESTART_TIME_US = 1000;          // restart delay, 1 ms
    localparam int RESTART_CYCLES  = RESTART_TIME_US * CLK_MHZ;
    localparam int CNT_W           = 20;            // restart counter width

    // apb byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;      // power-down, autoload
    localparam logic [7:0] OFS_FINT   = 8'h04;      // frac divider integer
    localparam logic [7:0] OFS_FNUM   = 8'h08;      // frac divider numerator
    localparam logic [7:0] OFS_CHDIV  = 8'h0C;      // channel/ref/state divs
    localparam logic [7:0] OFS_FMT    = 8'h10;      // formats, ref pin
    localparam logic [7:0] OFS_STATUS = 8'h14;      // read-only status
    localparam logic [7:0] OFS_TRIM   = 8'h18;      // resonator trim, ro

    // field positions
    localparam int CTRL_PDN_BIT  = 0;               // power_down_request
    localparam int CTRL_NVD_BIT  = 1;               // nv_autoload_disable
    localparam int CHD_CH0_LSB   = 0;               // chan0_divide [1:0]
    localparam int CHD_CH1_LSB   = 2;               // chan1_divide [3:2]
    localparam int CHD_REF_LSB   = 4;               // ref divide [5:4]
    localparam int CHD_SEL_BIT   = 8;               // out1_chan_select
    localparam int CHD_SCLK_LSB  = 12;              // state_clock_divide
    localparam int FMT_OUT0_LSB  = 0;               // out0_format [2:0]
    localparam int FMT_OUT1_LSB  = 4;               // out1_format [6:4]
    localparam int FMT_REF_LSB   = 8;               // ref_pin_function [9:8]

    // divider codes: only /2, /4, /8 exist, zero rounds up to /2
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;
    localparam logic [1:0] DIV_8 = 2'h3;

    // output format codes
    localparam logic [2:0] FMT_OFF         = 3'h0;
    localparam logic [2:0] FMT_LPHCSL      = 3'h1;
    localparam logic [2:0] FMT_LVDS        = 3'h2;
    localparam logic [2:0] FMT_LVCMOS_DIFF = 3'h3;  // p and ~p, cmos levels
    localparam logic [2:0] FMT_LVCMOS_INPH = 3'h4;  // p and p in phase

    // ref pin function codes
    localparam logic [1:0] REFPIN_INPUT  = 2'h0;
    localparam logic [1:0] REFPIN_CLKOUT = 2'h3;    // extra ref clock out

    // reset values, also restored by the nv page-zero autoload
    localparam logic [7:0]  FINT_RST  = 8'h0C;
    localparam logic [23:0] FNUM_RST  = 24'h000000;
    localparam logic [1:0]  CH0_RST   = DIV_2;
    localparam logic [1:0]  CH1_RST   = DIV_2;
    localparam logic [1:0]  REFD_RST  = DIV_8;
    localparam logic        SEL_RST   = 1'b0;       // out1 on channel 0
    localparam logic [3:0]  SCLK_RST  = 4'h2;
    localparam logic [2:0]  FMT_RST   = FMT_LPHCSL;
    localparam logic [1:0]  REFP_RST  = REFPIN_INPUT;

    // generator states
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,                         // outputs running
        ST_LOWPWR  = 2'b01,                         // held powered down
        ST_RESTART = 2'b10                          // waiting restart delay
    } gen_state_t;
endpackage

//--- hdl/clkgen_reprog.sv
/*
 * digital side of the resonator clock generator: apb register file,
 * power-down sequencing with timed restart, nv autoload, channel and
 * reference dividers, output format shaping and state-machine clock tick.
 * assumes clk_in stands for the channel-zero source clock and that the
 * trim value arrives from fuses on resonator_trim_in.
 */
// Decided for this implementation: the register offsets and the APB register port.
// Operation
// - outputs start about 1 ms after release
// - dividers give /2 /4 /8, no /5
// - out1 selects channel zero after reset
// - formats include differential lvcmos
// - ref pin can be extra clock output
// - autoload disable stops page-zero load
// - state clock is source over two plus divider
// - resonator trim is signed, read only
`timescale 1ns/1ps
module clkgen_reprog #(
    parameter int RESTART_CYCLES = clkgen_pkg::RESTART_CYCLES
) (
    input  wire logic        clk_in,            // 200 MHz system clock
    input  wire logic        reset_n_in,        // sync reset, active low
    input  wire logic        psel_in,           // apb select
    input  wire logic        penable_in,        // apb access phase
    input  wire logic        pwrite_in,         // apb write
    input  wire logic [7:0]  paddr_in,          // apb byte address
    input  wire logic [31:0] pwdata_in,         // apb write data
    input  wire logic [15:0] resonator_trim_in, // fused resonator trim
    output logic [31:0]      prdata_out,        // apb read data
    output logic             pready_out,        // apb ready
    output logic             pslverr_out,       // apb error
    output logic             out0_p_out,        // output 0 p phase
    output logic             out0_n_out,        // output 0 n phase
    output logic             out1_p_out,        // output 1 p phase
    output logic             out1_n_out,        // output 1 n phase
    output logic             ref_clk_out,       // ref pin clock output
    output logic             state_tick_out,    // state-machine clock tick
    output logic             running_out        // outputs running
);
    localparam logic [clkgen_pkg::CNT_W-1:0] RESTART_LAST =
        clkgen_pkg::CNT_W'(RESTART_CYCLES - 1);

    // the whole state of the block
    typedef struct packed {
        clkgen_pkg::gen_state_t         state;   // generator state
        logic [clkgen_pkg::CNT_W-1:0]   rcnt;    // restart counter
        logic                           power_down_request;     // power_down_request
        logic                           nvd;     // nv_autoload_disable
        logic [7:0]                     fint;    // frac_div0_integer
        logic [23:0]                    fnum;    // frac_div0_numerator
        logic [1:0]                     ch0div;  // chan0_divide
        logic [1:0]                     ch1div;  // chan1_divide
        logic [1:0]                     refdiv;  // ref divide
        logic                           sel1;    // out1_chan_select
        logic [3:0]                     sclk;    // state_clock_divide
        logic [2:0]                     fmt0;    // out0_format
        logic [2:0]                     fmt1;    // out1_format
        logic [1:0]                     refpin;  // ref_pin_function
        logic [2:0]                     dcnt;    // shared divide counter
        logic [4:0]                     scnt;    // state clock counter
        logic                           stick;   // state clock tick
        logic                           o0p;     // out0 p
        logic                           o0n;     // out0 n
        logic                           o1p;     // out1 p
        logic                           o1n;     // out1 n
        logic                           refclk;  // ref clock
        logic                           run;     // outputs running
        logic                           loaded;  // last restart autoloaded
        logic [31:0]                    rdata;   // apb read data
        logic                           rdy;     // apb ready
        logic                           err;     // apb error
    } st_t;

    st_t q;                                      // registered state
    st_t d;                                      // next state

    // picks a divided clock bit; zero code rounds up to /2
    function automatic logic div_bit(input logic [1:0] code,
                                     input logic [2:0] cnt);
        logic b;
        case (code)
            clkgen_pkg::DIV_4: b = cnt[1];
            clkgen_pkg::DIV_8: b = cnt[2];
            default:           b = cnt[0];
        endcase
        return b;
    endfunction

    logic        acc_wr;                         // write access taking effect
    logic        o0;                             // raw out0 clock
    logic        o1;                             // raw out1 clock
    logic        rck;                            // raw ref clock

    // next-state logic
    always_comb begin
        d = q;
        acc_wr = psel_in && penable_in && pwrite_in && q.rdy;
        // dividers run always; outputs gated by running
        d.dcnt = q.dcnt + 3'h1;
        o0  = div_bit(q.ch0div, q.dcnt);
        o1  = div_bit(q.sel1 ? q.ch1div : q.ch0div, q.dcnt);
        rck = div_bit(q.refdiv, q.dcnt);
        d.o0p = q.run && q.fmt0 != clkgen_pkg::FMT_OFF && o0;
        d.o1p = q.run && q.fmt1 != clkgen_pkg::FMT_OFF && o1;
        // in-phase cmos copies p, off drives 0, every other format drives ~p while running and 0 when stopped
        case (q.fmt0)
            clkgen_pkg::FMT_OFF:         d.o0n = 1'b0;
            clkgen_pkg::FMT_LVCMOS_INPH: d.o0n = q.run && o0;
            default:                     d.o0n = q.run && !o0;
        endcase
        case (q.fmt1)
            clkgen_pkg::FMT_OFF:         d.o1n = 1'b0;
            clkgen_pkg::FMT_LVCMOS_INPH: d.o1n = q.run && o1;
            default:                     d.o1n = q.run && !o1;
        endcase
        d.refclk = q.run && q.refpin == clkgen_pkg::REFPIN_CLKOUT
                   && rck;
        // state clock: one tick every 2 + divider source cycles
        if (q.scnt >= {1'b0, q.sclk} + 5'h01) begin
            d.scnt  = 5'h00;
            d.stick = 1'b1;
        end else begin
            d.scnt  = q.scnt + 5'h01;
            d.stick = 1'b0;
        end
        // generator sequencing
        case (q.state)
            clkgen_pkg::ST_RUN: begin
                if (q.power_down_request) begin
                    d.state = clkgen_pkg::ST_LOWPWR;
                    d.run   = 1'b0;
                end
            end
            clkgen_pkg::ST_LOWPWR: begin
                d.run = 1'b0;
                if (!q.power_down_request) begin
                    d.state  = clkgen_pkg::ST_RESTART;
                    d.rcnt   = '0;
                    d.loaded = !q.nvd;
                    // page-zero load unless disabled
                    if (!q.nvd) begin
                        d.fint   = clkgen_pkg::FINT_RST;
                        d.fnum   = clkgen_pkg::FNUM_RST;
                        d.ch0div = clkgen_pkg::CH0_RST;
                        d.ch1div = clkgen_pkg::CH1_RST;
                        d.refdiv = clkgen_pkg::REFD_RST;
                        d.sel1   = clkgen_pkg::SEL_RST;
                        d.sclk   = clkgen_pkg::SCLK_RST;
                        d.fmt0   = clkgen_pkg::FMT_RST;
                        d.fmt1   = clkgen_pkg::FMT_RST;
                        d.refpin = clkgen_pkg::REFP_RST;
                    end
                end
            end
            clkgen_pkg::ST_RESTART: begin
                if (q.power_down_request) begin
                    d.state = clkgen_pkg::ST_LOWPWR;
                end else if (q.rcnt == RESTART_LAST) begin
                    d.state = clkgen_pkg::ST_RUN;
                    d.run   = 1'b1;
                end else begin
                    d.rcnt = q.rcnt + 1'b1;
                end
            end
            default: d.state = clkgen_pkg::ST_LOWPWR;
        endcase
        // apb setup phase: decode, prepare answer for the access phase
        d.rdy = psel_in && !penable_in;
        if (psel_in && !penable_in) begin
            d.rdata = 32'h0000_0000;
            d.err   = 1'b0;
            case (paddr_in)
                clkgen_pkg::OFS_CTRL: begin
                    d.rdata[clkgen_pkg::CTRL_PDN_BIT] = q.power_down_request;
                    d.rdata[clkgen_pkg::CTRL_NVD_BIT] = q.nvd;
                end
                clkgen_pkg::OFS_FINT: d.rdata[7:0]  = q.fint;
                clkgen_pkg::OFS_FNUM: d.rdata[23:0] = q.fnum;
                clkgen_pkg::OFS_CHDIV: begin
                    d.rdata[clkgen_pkg::CHD_CH0_LSB +: 2] = q.ch0div;
                    d.rdata[clkgen_pkg::CHD_CH1_LSB +: 2] = q.ch1div;
                    d.rdata[clkgen_pkg::CHD_REF_LSB +: 2] = q.refdiv;
                    d.rdata[clkgen_pkg::CHD_SEL_BIT]      = q.sel1;
                    d.rdata[clkgen_pkg::CHD_SCLK_LSB +: 4] = q.sclk;
                end
                clkgen_pkg::OFS_FMT: begin
                    d.rdata[clkgen_pkg::FMT_OUT0_LSB +: 3] = q.fmt0;
                    d.rdata[clkgen_pkg::FMT_OUT1_LSB +: 3] = q.fmt1;
                    d.rdata[clkgen_pkg::FMT_REF_LSB +: 2]  = q.refpin;
                end
                clkgen_pkg::OFS_STATUS: d.rdata[4:0] =
                    {q.loaded, q.state, q.power_down_request, q.run};
                clkgen_pkg::OFS_TRIM: begin
                    d.rdata = {{16{resonator_trim_in[15]}},
                               resonator_trim_in};
                    d.err   = pwrite_in;
                end
                default: d.err = 1'b1;          // unmapped address
            endcase
        end
        // apb access phase: writes land on the ready edge
        if (acc_wr && !q.err) begin
            case (paddr_in)
                clkgen_pkg::OFS_CTRL: begin
                    d.power_down_request = pwdata_in[clkgen_pkg::CTRL_PDN_BIT];
                    d.nvd = pwdata_in[clkgen_pkg::CTRL_NVD_BIT];
                end
                clkgen_pkg::OFS_FINT: d.fint = pwdata_in[7:0];
                clkgen_pkg::OFS_FNUM: d.fnum = pwdata_in[23:0];
                clkgen_pkg::OFS_CHDIV: begin
                    d.ch0div = pwdata_in[clkgen_pkg::CHD_CH0_LSB +: 2];
                    d.ch1div = pwdata_in[clkgen_pkg::CHD_CH1_LSB +: 2];
                    d.refdiv = pwdata_in[clkgen_pkg::CHD_REF_LSB +: 2];
                    d.sel1   = pwdata_in[clkgen_pkg::CHD_SEL_BIT];
                    // state divider only moves while powered down
                    if (q.state == clkgen_pkg::ST_LOWPWR) begin
                        d.sclk = pwdata_in[clkgen_pkg::CHD_SCLK_LSB +: 4];
                    end
                end
                clkgen_pkg::OFS_FMT: begin
                    d.fmt0   = pwdata_in[clkgen_pkg::FMT_OUT0_LSB +: 3];
                    d.fmt1   = pwdata_in[clkgen_pkg::FMT_OUT1_LSB +: 3];
                    d.refpin = pwdata_in[clkgen_pkg::FMT_REF_LSB +: 2];
                end
                default: d.err = q.err;         // read-only or unmapped
            endcase
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q        <= '0;
            q.state  <= clkgen_pkg::ST_RESTART;
            q.fint   <= clkgen_pkg::FINT_RST;
            q.fnum   <= clkgen_pkg::FNUM_RST;
            q.ch0div <= clkgen_pkg::CH0_RST;
            q.ch1div <= clkgen_pkg::CH1_RST;
            q.refdiv <= clkgen_pkg::REFD_RST;
            q.sel1   <= clkgen_pkg::SEL_RST;
            q.sclk   <= clkgen_pkg::SCLK_RST;
            q.fmt0   <= clkgen_pkg::FMT_RST;
            q.fmt1   <= clkgen_pkg::FMT_RST;
            q.refpin <= clkgen_pkg::REFP_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata_out     = q.rdata;
    assign pready_out     = q.rdy;
    assign pslverr_out    = q.err;
    assign out0_p_out     = q.o0p;
    assign out0_n_out     = q.o0n;
    assign out1_p_out     = q.o1p;
    assign out1_n_out     = q.o1n;
    assign ref_clk_out    = q.refclk;
    assign state_tick_out = q.stick;
    assign running_out    = q.run;

    // checks on the generator behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    AST_PDN_HOLDS: assert property (
        q.power_down_request && q.state == clkgen_pkg::ST_RUN
        |=> q.state == clkgen_pkg::ST_LOWPWR ##1 !q.run)
        else $error("power-down did not stop outputs");
    AST_RESTART_DELAY: assert property (
        $rose(q.run) |-> $past(q.rcnt) == RESTART_LAST
                         && $past(q.state) == clkgen_pkg::ST_RESTART)
        else $error("outputs started before restart delay");
    AST_DIV8_SHAPE: assert property (
        q.run && $past(q.run) && q.ch0div == clkgen_pkg::DIV_8
        && $stable(q.ch0div) && q.fmt0 != clkgen_pkg::FMT_OFF
        |=> q.o0p == $past(q.dcnt[2]))
        else $error("out0 not on divide by eight");
    AST_SEL_RESET: assert property (
        $rose(reset_n_in) |-> !q.sel1)
        else $error("out1 select not channel zero after reset");
    AST_LVCMOS_DIFF: assert property (
        q.fmt0 == clkgen_pkg::FMT_LVCMOS_DIFF [*2] ##0 q.run
        |=> q.o0n == !q.o0p)
        else $error("differential cmos phases not opposite");
    AST_REF_OFF: assert property (
        q.refpin != clkgen_pkg::REFPIN_CLKOUT |=> !q.refclk)
        else $error("ref clock driven while pin not an output");
    AST_AUTOLOAD: assert property (
        q.state == clkgen_pkg::ST_LOWPWR && !q.power_down_request && q.nvd
        |=> $stable(q.fint) && $stable(q.fmt0) && !q.loaded)
        else $error("page zero loaded though disabled");
    AST_SCLK_TICK: assert property (
        q.stick && $stable(q.sclk) && q.sclk == $past(q.sclk, 2)
        |-> $past(q.scnt) == {1'b0, q.sclk} + 5'h01)
        else $error("state clock tick at wrong count");
    AST_SCLK_GUARD: assert property (
        acc_wr && paddr_in == clkgen_pkg::OFS_CHDIV
        && q.state != clkgen_pkg::ST_LOWPWR |=> $stable(q.sclk))
        else $error("state divider changed while running");
    AST_TRIM_RO: assert property (
        psel_in && !penable_in && pwrite_in
        && paddr_in == clkgen_pkg::OFS_TRIM |=> q.err && q.rdy)
        else $error("trim write not refused");

    COV_RESTART: cover property ($fell(q.power_down_request) ##[1:5] q.state ==
                                 clkgen_pkg::ST_RESTART);
    COV_RUNNING: cover property ($rose(q.run));
    COV_REFCLK:  cover property (q.refclk);
    COV_BADADDR: cover property (q.err && q.rdy);
endmodule

//--- sim/host_model.sv
/*
 * apb host model that reprograms the clock generator registers.
 * assumes one clock and registered pready from the slave.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_in,      // system clock
    input  wire logic        pready_in,   // slave ready
    input  wire logic        pslverr_in,  // slave error
    input  wire logic [31:0] prdata_in,   // slave read data
    output logic             psel_out,    // select
    output logic             penable_out, // access phase
    output logic             pwrite_out,  // direction
    output logic [7:0]       paddr_out,   // byte address
    output logic [31:0]      pwdata_out   // write data
);
    // idle bus at time zero
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
    end

    // one transfer: setup, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err, output logic hung);
        int n;
        begin
            n = 0;
            @(posedge clk_in);
            psel_out <= 1'b1;
            pwrite_out <= w;
            paddr_out <= a;
            pwdata_out <= d;
            @(posedge clk_in);
            penable_out <= 1'b1;
            do begin
                @(posedge clk_in);
                n++;
            end while (pready_in !== 1'b1 && n < 16);
            rd = prdata_in;
            err = pslverr_in;
            hung = (n >= 16);
            // released lines show no stale value
            psel_out <= 1'b0;
            penable_out <= 1'b0;
            paddr_out <= ~a;
            pwdata_out <= ~d;
        end
    endtask
endmodule

//--- sim/tb_top.sv
/*
 * testbench: reset values, trim readout, refusals, full retune
 * sequence, autoload restore and divided output rates.
 * assumes the design package is compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int RC = 20;                 // shortened restart delay
    logic clk_in, reset_n_in, psel, penable, pwrite;   // bus and reset
    logic [7:0] paddr;                      // byte address
    logic [31:0] pwdata, prdata;            // bus data
    logic pready, pslverr, o0p, o0n, o1p, o1n, refc, tick, run;
    logic [15:0] trim;                      // fused trim
    logic [31:0] c0, c1, cr, ct, bad;       // watch results
    int n_fail, checks_done;                // counters
    clkgen_reprog #(.RESTART_CYCLES(RC)) DUT (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .resonator_trim_in(trim), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .out0_p_out(o0p),
        .out0_n_out(o0n), .out1_p_out(o1p), .out1_n_out(o1n),
        .ref_clk_out(refc), .state_tick_out(tick), .running_out(run));
    host_model host (.clk_in(clk_in), .pready_in(pready),
        .pslverr_in(pslverr), .prdata_in(prdata), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata));
    // 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // verdict and stop
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // value compare
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    // bus access, hang ends the run
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic e_exp);
        logic [31:0] r;
        logic e, h;
        begin
            host.xfer(w, a, d, r, e, h);
            if (h) begin
                n_fail++;
                end_of_test();
            end
            if (!w) chk(r, exp, "read data");
            chk({31'h0, e}, {31'h0, e_exp}, "error flag");
        end
    endtask
    // bounded wait for running outputs, delay in window
    task automatic wait_run(input int lo, input int hi);
        int n;
        begin
            n = 0;
            while (run !== 1'b1 && n < 1000) begin
                @(posedge clk_in);
                n++;
            end
            chk({31'h0, n >= lo && n <= hi}, 32'h1, "restart delay");
            // a restart that never comes ends the run
            if (run !== 1'b1) end_of_test();
        end
    endtask
    // count output toggles and ticks, check complementary phases
    task automatic watch(input int cyc);
        logic p0, p1, pr;
        begin
            c0 = 0; c1 = 0; cr = 0; ct = 0; bad = 0;
            @(negedge clk_in);
            p0 = o0p; p1 = o1p; pr = refc;
            repeat (cyc) begin
                @(negedge clk_in);
                c0 += 32'(o0p !== p0);
                c1 += 32'(o1p !== p1);
                cr += 32'(refc !== pr);
                ct += 32'(tick === 1'b1);
                bad += 32'(o0n !== ~o0p || o1n !== ~o1p);
                p0 = o0p; p1 = o1p; pr = refc;
            end
        end
    endtask
    // main sequence
    initial begin
        reset_n_in = 1'b0;
        trim = 16'h3701;
        n_fail = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        wait_run(RC, RC + 4);
        acc(0, clkgen_pkg::OFS_CHDIV, 0, 32'h2035, 0);
        acc(0, clkgen_pkg::OFS_FMT, 0, 32'h0011, 0);
        acc(0, clkgen_pkg::OFS_TRIM, 0, 32'h3701, 0);
        acc(1, clkgen_pkg::OFS_TRIM, 32'h1234, 0, 1);
        acc(0, clkgen_pkg::OFS_TRIM, 0, 32'h3701, 0);
        acc(1, 8'h1C, 32'h5, 0, 1);
        acc(0, 8'h1C, 0, 32'h0, 1);
        // retune to 25 MHz cmos pairs plus ref clock
        acc(1, clkgen_pkg::OFS_CTRL, 32'h1, 0, 0);
        repeat (3) @(posedge clk_in);
        chk({31'h0, run}, 32'h0, "held in low power");
        acc(1, clkgen_pkg::OFS_FINT, 32'h0C, 0, 0);
        acc(1, clkgen_pkg::OFS_FNUM, 32'hDF430D, 0, 0);
        acc(1, clkgen_pkg::OFS_CHDIV, 32'h2037, 0, 0);
        acc(1, clkgen_pkg::OFS_FMT, 32'h0333, 0, 0);
        acc(1, clkgen_pkg::OFS_CTRL, 32'h3, 0, 0);
        acc(1, clkgen_pkg::OFS_CTRL, 32'h2, 0, 0);
        wait_run(RC, RC + 4);
        acc(0, clkgen_pkg::OFS_FNUM, 0, 32'hDF430D, 0);
        acc(0, clkgen_pkg::OFS_FMT, 0, 32'h0333, 0);
        acc(0, clkgen_pkg::OFS_FINT, 0, 32'h0C, 0);
        acc(0, clkgen_pkg::OFS_CHDIV, 0, 32'h2037, 0);
        acc(0, clkgen_pkg::OFS_STATUS, 0, 32'h01, 0);
        watch(64);
        chk(c0, 32'd16, "out0 divide by 8");
        chk(c1, 32'd16, "out1 follows channel 0");
        chk(cr, 32'd16, "ref clock divide by 8");
        chk(ct, 32'd16, "state tick every 4");
        chk(bad, 32'd0, "cmos pair not complementary");
        // state divider ignored while running
        acc(1, clkgen_pkg::OFS_CHDIV, 32'h5037, 0, 0);
        acc(0, clkgen_pkg::OFS_CHDIV, 0, 32'h2037, 0);
        // out0 off, out1 cmos in phase
        acc(1, clkgen_pkg::OFS_FMT, 32'h0343, 0, 0);
        acc(1, clkgen_pkg::OFS_FMT, 32'h0340, 0, 0);
        repeat (2) @(negedge clk_in);
        chk({30'h0, o1n, o0p | o0n}, {30'h0, o1p, 1'b0}, "fmt");
        // state divider 5 taken in low power
        acc(1, clkgen_pkg::OFS_CTRL, 32'h3, 0, 0);
        acc(1, clkgen_pkg::OFS_CHDIV, 32'h5037, 0, 0);
        acc(1, clkgen_pkg::OFS_CTRL, 32'h2, 0, 0);
        wait_run(RC, RC + 4);
        watch(63);
        chk(ct, 32'd9, "state tick every 7");
        // autoload enabled restores page-zero values
        acc(1, clkgen_pkg::OFS_CTRL, 32'h1, 0, 0);
        acc(1, clkgen_pkg::OFS_CTRL, 32'h0, 0, 0);
        wait_run(RC, RC + 4);
        acc(0, clkgen_pkg::OFS_CHDIV, 0, 32'h2035, 0);
        acc(0, clkgen_pkg::OFS_FINT, 0, 32'h0C, 0);
        acc(0, clkgen_pkg::OFS_STATUS, 0, 32'h11, 0);
        trim <= 16'h8001;
        acc(0, clkgen_pkg::OFS_TRIM, 0, 32'hFFFF8001, 0);
        end_of_test();
    end
endmodule
